//--- sysctl_defs.vh
// Offsets, field positions, reset values and timing constants of the
// system control flag bank. Assumes APB with 32-bit data and pclk at 250 MHz.
// Contract
// - Option bit 7 puts the first serial port into one-wire pin sharing.
// - Watchdog field 5:4 selects 480, 240, 120 or 60 ms overflow.
// - Converter field 3:2 divides system clock by 32, 16, 8 or 4.
// - Tick field 1:0 selects 32768, 16384, 8192 or 128 slow-clock cycles.
// - Flag bit 7 is read-only and set by the low-voltage detector.
// - Touch-done bit 5 set at conversion end; cleared by DFh or touch start.
// - Converter-done bit 4 set at conversion end; cleared by EFh or start.
// - Port-1 change bit 1 set by enabled pin change; irq enable ignored.
// - Port-1 change flag clears on service entry or on writing FDh.
// - Tick flag bit 0 set at count; clears on service or FEh write.
// - Port-1 wake register gives one enable per pin, reset 00h.
// - Writing 56h to the command register issues a software reset.
// - Writing 65h sets the flash unlock flag; other values clear it.
// - Command register reads watchdog timeout bit 1, unlock bit 0, reset 0.
// - Unlock status combines with the area lock to select programmable sectors.
`ifndef SYSCTL_DEFS_VH
`define SYSCTL_DEFS_VH

`define IDX_OPTION         8'h94
`define IDX_FLAGS          8'h95
`define IDX_P1WAKE         8'h96
`define IDX_CMD            8'h97
`define IDX_IRQ_STATUS     8'h98
`define IDX_IRQ_MASK       8'h99

`define OPT_ONE_WIRE       7
`define OPT_WDT_HI         5
`define OPT_WDT_LO         4
`define OPT_CONV_HI        3
`define OPT_CONV_LO        2
`define OPT_TICK_HI        1
`define OPT_TICK_LO        0

`define FLG_LOW_VOLT       7
`define FLG_TOUCH          5
`define FLG_CONV           4
`define FLG_PORT1          1
`define FLG_TICK           0

`define CMD_WATCHDOG_TIMEOUT_FLAG_BIT       1
`define CMD_UNLOCK_BIT     0
`define CMD_SOFT_RESET     8'h56
`define CMD_UNLOCK         8'h65

`define OPTION_RESET       8'h00
`define P1WAKE_RESET       8'h00

`define WDT_MS_0           10'd480
`define WDT_MS_1           10'd240
`define WDT_MS_2           10'd120
`define WDT_MS_3           10'd60
`define CONV_DIV_0         6'd32
`define CONV_DIV_1         6'd16
`define CONV_DIV_2         6'd8
`define CONV_DIV_3         6'd4
`define TICK_CYC_0         16'd32768
`define TICK_CYC_1         16'd16384
`define TICK_CYC_2         16'd8192
`define TICK_CYC_3         16'd128

`define IRQ_TICK           0
`define IRQ_PORT1          1
`define IRQ_CONV           2
`define IRQ_TOUCH          3
`define IRQ_LOW_VOLT       4
`define IRQ_WATCHDOG_TIMEOUT_FLAG           5
`define IRQ_BITS           6

`endif

//--- rate_divider.v
// Programmable rate divider: a counter that emits a one-cycle pulse
// every terminal count of enabled cycles.
// Assumes the terminal value is at least one and changes only rarely.
`default_nettype none

module rate_divider #(
  parameter WIDTH = 16
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             count_en,
  input  wire [WIDTH-1:0] period,
  output reg              tick_q
);

  reg [WIDTH-1:0] count_q;

  // A period shrunk below the running count wraps at once instead of
  // waiting for a full counter roll-over.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= {WIDTH{1'b0}};
      tick_q  <= 1'b0;
    end
    else
    begin
      tick_q <= 1'b0;
      if (count_en)
      begin
        if (count_q >= period - {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          count_q <= {WIDTH{1'b0}};
          tick_q  <= 1'b1;
        end
        else
        begin
          count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // rate_divider

`default_nettype wire

//--- sysctl_flag_bank.v
// System control flag bank: option selections, interrupt flags,
// port-1 wake enables and the software command register, on APB.
// Assumes event inputs are one-cycle pulses synchronous to pclk and
// that slow_tick is a one-cycle enable at the slow clock rate.
//
// The APB slave port was decided locally.
`default_nettype none
`include "sysctl_defs.vh"

module sysctl_flag_bank (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        low_voltage_detect,
  input  wire        touch_conv_end,
  input  wire        sysclk_fast_enough,
  input  wire        touch_start_bit,
  input  wire        converter_conv_end,
  input  wire        converter_start_bit,
  input  wire [7:0]  port1_pins,
  input  wire        port1_isr_enter,
  input  wire        tick_isr_enter,
  input  wire        slow_tick,
  input  wire        watchdog_timeout,
  input  wire [1:0]  flash_area_lock,
  output reg         serial_one_wire_sel,
  output reg  [9:0]  watchdog_period_ms,
  output wire        converter_clk_en,
  output reg         soft_reset_pulse,
  output reg         iap_enable,
  output reg  [1:0]  iap_area_sel,
  output reg  [7:0]  port1_wake_enable,
  output wire        irq
);

  reg [7:0]  option_q;
  reg        low_voltage_flag_q;
  reg        touch_done_flag_q;
  reg        converter_done_flag_q;
  reg        port1_change_flag_q;
  reg        tick_timer_flag_q;
  reg        watchdog_timeout_flag_q;
  reg        flash_program_unlock_q;
  reg [7:0]  port1_prev_q;
  reg [`IRQ_BITS-1:0] irq_status_q;
  reg [`IRQ_BITS-1:0] irq_mask_q;
  reg [`IRQ_BITS-1:0] irq_status_d;
  reg [5:0]  conv_div;
  reg [15:0] tick_cycles;
  reg [7:0]  read_mux;
  reg        addr_hit;
  wire       tick_pulse;
  wire [9:0] word_idx;
  wire       wr_acc;
  wire       rd_acc;
  wire       wr_flags;
  wire       wr_cmd;
  wire [7:0] wbyte;
  wire       port1_change;
  wire       low_voltage_rise;
  wire [7:0] flags_read;
  wire [7:0] cmd_read;
  wire [`IRQ_BITS-1:0] irq_events;

  assign word_idx = paddr[11:2];
  assign wbyte    = pwdata[7:0];
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_hit;
  // Only the low byte lane carries register data.
  assign wr_acc   = psel && penable && pwrite && addr_hit && pstrb[0];
  assign rd_acc   = psel && penable && !pwrite && addr_hit;
  assign wr_flags = wr_acc && (word_idx == {2'b00, `IDX_FLAGS});
  assign wr_cmd   = wr_acc && (word_idx == {2'b00, `IDX_CMD});

  always @*
  begin
    case (word_idx)
      {2'b00, `IDX_OPTION},
      {2'b00, `IDX_FLAGS},
      {2'b00, `IDX_P1WAKE},
      {2'b00, `IDX_CMD},
      {2'b00, `IDX_IRQ_STATUS},
      {2'b00, `IDX_IRQ_MASK}:
        addr_hit = 1'b1;
      default:
        addr_hit = 1'b0;
    endcase
  end

  always @*
  begin
    case (option_q[`OPT_WDT_HI:`OPT_WDT_LO])
      2'b00:   watchdog_period_ms = `WDT_MS_0;
      2'b01:   watchdog_period_ms = `WDT_MS_1;
      2'b10:   watchdog_period_ms = `WDT_MS_2;
      default: watchdog_period_ms = `WDT_MS_3;
    endcase
  end

  always @*
  begin
    case (option_q[`OPT_CONV_HI:`OPT_CONV_LO])
      2'b00:   conv_div = `CONV_DIV_0;
      2'b01:   conv_div = `CONV_DIV_1;
      2'b10:   conv_div = `CONV_DIV_2;
      default: conv_div = `CONV_DIV_3;
    endcase
  end

  always @*
  begin
    case (option_q[`OPT_TICK_HI:`OPT_TICK_LO])
      2'b00:   tick_cycles = `TICK_CYC_0;
      2'b01:   tick_cycles = `TICK_CYC_1;
      2'b10:   tick_cycles = `TICK_CYC_2;
      default: tick_cycles = `TICK_CYC_3;
    endcase
  end

  always @*
  begin
    serial_one_wire_sel = option_q[`OPT_ONE_WIRE];
  end

  rate_divider #(
    .WIDTH (6)
  ) u_conv_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .count_en (1'b1),
    .period   (conv_div),
    .tick_q   (converter_clk_en)
  );

  rate_divider #(
    .WIDTH (16)
  ) u_tick_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .count_en (slow_tick),
    .period   (tick_cycles),
    .tick_q   (tick_pulse)
  );

  assign port1_change = |((port1_pins ^ port1_prev_q) & port1_wake_enable);
  assign low_voltage_rise = low_voltage_detect && !low_voltage_flag_q;

  assign flags_read = {low_voltage_flag_q, 1'b0, touch_done_flag_q,
                       converter_done_flag_q, 2'b00, port1_change_flag_q,
                       tick_timer_flag_q};
  assign cmd_read = {6'h00, watchdog_timeout_flag_q, flash_program_unlock_q};

  always @*
  begin
    case (word_idx)
      {2'b00, `IDX_OPTION}:     read_mux = option_q;
      {2'b00, `IDX_FLAGS}:      read_mux = flags_read;
      {2'b00, `IDX_P1WAKE}:     read_mux = port1_wake_enable;
      {2'b00, `IDX_CMD}:        read_mux = cmd_read;
      {2'b00, `IDX_IRQ_STATUS}: read_mux = {2'b00, irq_status_q};
      {2'b00, `IDX_IRQ_MASK}:   read_mux = {2'b00, irq_mask_q};
      default:                  read_mux = 8'h00;
    endcase
  end

  // Read data is latched in the setup phase so that a read-to-clear
  // status access returns the bits it is about to clear.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h00_0000, read_mux};
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      option_q          <= `OPTION_RESET;
      port1_wake_enable <= `P1WAKE_RESET;
      irq_mask_q        <= {`IRQ_BITS{1'b0}};
      port1_prev_q      <= 8'h00;
    end
    else
    begin
      port1_prev_q <= port1_pins;
      if (wr_acc && word_idx == {2'b00, `IDX_OPTION})
        option_q <= wbyte;
      if (wr_acc && word_idx == {2'b00, `IDX_P1WAKE})
        port1_wake_enable <= wbyte;
      if (wr_acc && word_idx == {2'b00, `IDX_IRQ_MASK})
        irq_mask_q <= wbyte[`IRQ_BITS-1:0];
    end
  end

  // Every flag: the hardware set wins over a clear in the same cycle.
  // low voltage read-only
  // The flag mirrors the detector, so no write can clear it.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_voltage_flag_q <= 1'b0;
    else
      low_voltage_flag_q <= low_voltage_detect;
  end

  // touch done flag
  // A conversion that ends on too slow a system clock leaves the flag alone.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      touch_done_flag_q <= 1'b0;
    else if (touch_conv_end && sysclk_fast_enough)
      touch_done_flag_q <= 1'b1;
    else if (touch_start_bit)
      touch_done_flag_q <= 1'b0;
    else if (wr_flags && !wbyte[`FLG_TOUCH])
      touch_done_flag_q <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      converter_done_flag_q <= 1'b0;
    else if (converter_conv_end)
      converter_done_flag_q <= 1'b1;
    else if (converter_start_bit)
      converter_done_flag_q <= 1'b0;
    else if (wr_flags && !wbyte[`FLG_CONV])
      converter_done_flag_q <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port1_change_flag_q <= 1'b0;
    else if (port1_change)
      port1_change_flag_q <= 1'b1;
    else if (port1_isr_enter || (wr_flags && !wbyte[`FLG_PORT1]))
      port1_change_flag_q <= 1'b0;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_timer_flag_q <= 1'b0;
    else if (tick_pulse)
      tick_timer_flag_q <= 1'b1;
    else if (tick_isr_enter || (wr_flags && !wbyte[`FLG_TICK]))
      tick_timer_flag_q <= 1'b0;
  end

  // The timeout flag can only be cleared by reset; a software reset
  // leaves it standing so firmware can tell why it restarted.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      watchdog_timeout_flag_q <= 1'b0;
      flash_program_unlock_q  <= 1'b0;
      soft_reset_pulse        <= 1'b0;
    end
    else
    begin
      if (watchdog_timeout)
        watchdog_timeout_flag_q <= 1'b1;
      soft_reset_pulse <= wr_cmd && (wbyte == `CMD_SOFT_RESET);
      if (wr_cmd)
        flash_program_unlock_q <= (wbyte == `CMD_UNLOCK);
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      iap_enable   <= 1'b0;
      iap_area_sel <= 2'b00;
    end
    else
    begin
      iap_enable   <= flash_program_unlock_q;
      iap_area_sel <= flash_program_unlock_q ? flash_area_lock : 2'b00;
    end
  end

  assign irq_events = {watchdog_timeout && !watchdog_timeout_flag_q,
                       low_voltage_rise,
                       touch_conv_end && sysclk_fast_enough,
                       converter_conv_end,
                       port1_change,
                       tick_pulse};

  // Sticky status cleared by a read; a new event wins over the clear.
  // Only the bits returned by the read are cleared, so an event that lands
  // between the setup and the access cycle is not lost.
  always @*
  begin
    irq_status_d = irq_status_q;
    if (rd_acc && word_idx == {2'b00, `IDX_IRQ_STATUS})
      irq_status_d = irq_status_q & ~prdata[`IRQ_BITS-1:0];
    irq_status_d = irq_status_d | irq_events;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_q <= {`IRQ_BITS{1'b0}};
    else
      irq_status_q <= irq_status_d;
  end

  assign irq = |(irq_status_q & irq_mask_q);

endmodule // sysctl_flag_bank

`default_nettype wire

//--- sysctl_flag_bank_props.sv
// Concurrent checks for the system control flag bank top module.
// Assumes byte addresses of four times the register index.
`default_nettype none

module sysctl_flag_bank_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        serial_one_wire_sel,
  input wire logic [9:0]  watchdog_period_ms,
  input wire logic        converter_clk_en,
  input wire logic        soft_reset_pulse,
  input wire logic        iap_enable,
  input wire logic [7:0]  port1_wake_enable
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic       wr;
  logic [9:0] idx;
  assign wr  = psel && penable && pwrite && pstrb[0];
  assign idx = paddr[11:2];

  a_soft_reset_pulse: assert property (wr && idx == 10'h097 && pwdata[7:0] == 8'h56
    |=> soft_reset_pulse) else $error("soft reset pulse missing");
  a_no_stray_reset: assert property (!(wr && idx == 10'h097 && pwdata[7:0] == 8'h56)
    |=> !soft_reset_pulse) else $error("unexpected soft reset pulse");
  a_unlock_set: assert property (wr && idx == 10'h097 && pwdata[7:0] == 8'h65
    |-> ##2 iap_enable) else $error("unlock not set");
  a_unlock_clear: assert property (wr && idx == 10'h097 && pwdata[7:0] != 8'h65
    |-> ##2 !iap_enable) else $error("unlock not cleared");
  a_one_wire_sel: assert property (wr && idx == 10'h094
    |=> serial_one_wire_sel == $past(pwdata[7])) else $error("one-wire select wrong");
  a_wdt_period: assert property (wr && idx == 10'h094
    |=> watchdog_period_ms == (10'd480 >> $past(pwdata[5:4]))) else $error("period wrong");
  a_wake_write: assert property (wr && idx == 10'h096
    |=> port1_wake_enable == $past(pwdata[7:0])) else $error("wake enable wrong");
  a_conv_min_gap: assert property (converter_clk_en
    |=> !converter_clk_en [*3]) else $error("converter clock too fast");

  cover property (soft_reset_pulse);
  cover property (iap_enable);
  cover property (converter_clk_en ##4 converter_clk_en);
endmodule // sysctl_flag_bank_props

bind sysctl_flag_bank sysctl_flag_bank_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .serial_one_wire_sel, .watchdog_period_ms,
  .converter_clk_en, .soft_reset_pulse, .iap_enable, .port1_wake_enable);

`default_nettype wire

//--- test_system_control_flag_bank.sv
// Self-checking bench for the system control flag bank over APB.
// Assumes the design, its header and the bound checker are compiled first.
`default_nettype none
`include "sysctl_defs.vh"

module test_system_control_flag_bank;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, err, serial_one_wire_sel, converter_clk_en;
  logic        soft_reset_pulse, iap_enable, irq;
  logic        low_voltage_detect = 1'h0, touch_conv_end = 1'h0, sysclk_fast_enough = 1'h0;
  logic        touch_start_bit = 1'h0, converter_conv_end = 1'h0, converter_start_bit = 1'h0;
  logic        port1_isr_enter = 1'h0, tick_isr_enter = 1'h0, slow_tick = 1'h0;
  logic        watchdog_timeout = 1'h0;
  logic [7:0]  port1_pins = 8'h00, port1_wake_enable;
  logic [1:0]  flash_area_lock = 2'h2, iap_area_sel;
  logic [9:0]  watchdog_period_ms;
  int          failures = 0, total_checks = 0;

  sysctl_flag_bank dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .low_voltage_detect, .touch_conv_end, .sysclk_fast_enough,
    .touch_start_bit, .converter_conv_end, .converter_start_bit, .port1_pins,
    .port1_isr_enter, .tick_isr_enter, .slow_tick, .watchdog_timeout, .flash_area_lock,
    .serial_one_wire_sel, .watchdog_period_ms, .converter_clk_en, .soft_reset_pulse,
    .iap_enable, .iap_area_sel, .port1_wake_enable, .irq);

  always #2 pclk = ~pclk;

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high, for at most 20 extra cycles before the run is ended as failed.
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
    begin
      failures++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'h0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic t_reset();
    rdchk(`IDX_OPTION, 8'h00);
    rdchk(`IDX_P1WAKE, 8'h00);
    rdchk(`IDX_CMD, 8'h00);
  endtask

  task automatic t_tick();
    xfer(1'h1, `IDX_OPTION, 8'h03);
    slow_tick <= 1'h1;
    repeat (127) @(posedge pclk);
    slow_tick <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h00);
    slow_tick <= 1'h1;
    @(posedge pclk);
    slow_tick <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h01);
    tick_isr_enter <= 1'h1;
    @(posedge pclk);
    tick_isr_enter <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h00);
  endtask

  // Periods grow from code to code so the divider overshoots its new end count only at the first code, after the 32-cycle period left by t_tick.
  task automatic t_option();
    int n;
    logic [7:0] d;
    for (int c = 3; c >= 0; c--)
    begin
      d = {c[0], 1'h0, c[1:0], c[1:0], 2'h0};
      xfer(1'h1, `IDX_OPTION, d);
      #1;
      chk(serial_one_wire_sel, c[0]);
      chk(watchdog_period_ms, 480 >> c);
      rdchk(`IDX_OPTION, d);
      repeat (2)
      begin
        n = 0;
        do
        begin
          @(posedge pclk);
          n++;
        end while (converter_clk_en !== 1'h1 && n < 99);
        if (n >= 99)
        begin
          failures++;
          summarize();
        end
      end
      chk(n, 32 >> c);
    end
  endtask

  task automatic t_flags();
    low_voltage_detect <= 1'h1;
    converter_conv_end <= 1'h1;
    touch_conv_end <= 1'h1;
    @(posedge pclk);
    converter_conv_end <= 1'h0;
    touch_conv_end <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h90);
    sysclk_fast_enough <= 1'h1;
    touch_conv_end <= 1'h1;
    @(posedge pclk);
    touch_conv_end <= 1'h0;
    rdchk(`IDX_FLAGS, 8'hb0);
    xfer(1'h1, `IDX_FLAGS, 8'hff);
    rdchk(`IDX_FLAGS, 8'hb0);
    xfer(1'h1, `IDX_FLAGS, 8'hdf);
    rdchk(`IDX_FLAGS, 8'h90);
    xfer(1'h1, `IDX_FLAGS, 8'h6f);
    rdchk(`IDX_FLAGS, 8'h80);
    converter_conv_end <= 1'h1;
    touch_conv_end <= 1'h1;
    @(posedge pclk);
    converter_conv_end <= 1'h0;
    touch_conv_end <= 1'h0;
    converter_start_bit <= 1'h1;
    touch_start_bit <= 1'h1;
    @(posedge pclk);
    converter_start_bit <= 1'h0;
    touch_start_bit <= 1'h0;
    low_voltage_detect <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h00);
  endtask

  task automatic t_port1();
    xfer(1'h1, `IDX_P1WAKE, 8'h04);
    port1_pins <= 8'h08;
    rdchk(`IDX_FLAGS, 8'h00);
    port1_pins <= 8'h0c;
    rdchk(`IDX_FLAGS, 8'h02);
    port1_isr_enter <= 1'h1;
    @(posedge pclk);
    port1_isr_enter <= 1'h0;
    rdchk(`IDX_FLAGS, 8'h00);
    port1_pins <= 8'h08;
    rdchk(`IDX_FLAGS, 8'h02);
    xfer(1'h1, `IDX_FLAGS, 8'hfd);
    rdchk(`IDX_FLAGS, 8'h00);
  endtask

  task automatic t_cmd();
    xfer(1'h1, `IDX_CMD, 8'h65);
    @(posedge pclk);
    #1;
    chk({iap_enable, iap_area_sel}, 3'h6);
    rdchk(`IDX_CMD, 8'h01);
    xfer(1'h1, `IDX_CMD, 8'h56);
    #1;
    chk(soft_reset_pulse, 1'h1);
    rdchk(`IDX_CMD, 8'h00);
    watchdog_timeout <= 1'h1;
    @(posedge pclk);
    watchdog_timeout <= 1'h0;
    rdchk(`IDX_CMD, 8'h02);
  endtask

  task automatic t_irq();
    rdchk(`IDX_IRQ_STATUS, 8'h3f);
    rdchk(`IDX_IRQ_STATUS, 8'h00);
    xfer(1'h1, `IDX_IRQ_MASK, 8'h04);
    rdchk(`IDX_IRQ_MASK, 8'h04);
    converter_conv_end <= 1'h1;
    @(posedge pclk);
    converter_conv_end <= 1'h0;
    #1;
    chk(irq, 1'h1);
    rdchk(`IDX_IRQ_STATUS, 8'h04);
    #1;
    chk(irq, 1'h0);
    xfer(1'h0, 8'h90, 8'h00);
    chk(err, 1'h1);
    chk(rd, 32'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_tick();
    t_option();
    t_flags();
    t_port1();
    t_cmd();
    t_irq();
    summarize();
  end
endmodule // test_system_control_flag_bank

`default_nettype wire
